/* File: swt_pkg.sv */
// constants for the sleep wake countdown timers
package swt_pkg;
    localparam int          SWT_NUM      = 2;
    localparam int          SWT_CNT_W    = 41;
    localparam int          SWT_REF_W    = 32;
    localparam logic [40:0] SWT_ROLL_VAL = 41'h001ffffffff;
    localparam logic [40:0] SWT_CNT_ONE  = 41'h00000000001;
    localparam logic [40:0] SWT_CNT_ZERO = 41'h00000000000;
    localparam logic [40:0] SWT_CAL_LOAD = 41'h00000000014;
    localparam logic [31:0] SWT_REF_ZERO = 32'h00000000;
    localparam logic [31:0] SWT_REF_ONE  = 32'h00000001;
    localparam int          SWT_CAL_NOMINAL = 10000;
    localparam int          SWT_MS_PERIODS  = 32;
endpackage : swt_pkg

/* File: swt_wake_timers.sv */
// two 41-bit wake timers with slow clock calibration
// Behaviour
// - two independent wake timers, each a 41-bit down-counter
// - timers count on slow clock ticks, asleep or awake
// - started timer counts down; zero gives interrupt awake, wake event asleep
// - zero interrupt or wake event only when that timer's interrupt enable is set
// - start value is counted in slow clock periods, 32 is about 1 ms
// - the tick reaching zero fires the timer, the next tick reloads 0x1FFFFFFFF and it keeps counting; timer 0 stops at zero in calibration
// - stop freezes the count; a stopped timer never fires
// - live count is always visible and reading it disturbs nothing
// - one running flag per timer
// - one fired flag per timer, cleared by the read-and-clear strobe
// - calibration loads timer 0 with 20, clears and starts reference counter
// - timer 0 zero in calibration stops reference counter, result captured
// - result is 10000 at nominal slow clock, more if slow, less if fast
`timescale 1ns/1ps
module swt_wake_timers
    import swt_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 slow_clk_i,
    input  wire logic                 ref_clk_i,
    input  wire logic                 asleep_i,
    input  wire logic [SWT_NUM-1:0]   start_i,
    input  wire logic [SWT_NUM-1:0]   stop_i,
    input  wire logic [SWT_CNT_W-1:0] start_val0_i,
    input  wire logic [SWT_CNT_W-1:0] start_val1_i,
    input  wire logic [SWT_NUM-1:0]   int_en_i,
    input  wire logic                 fired_clear_i,
    input  wire logic                 cal_start_i,
    output logic [SWT_CNT_W-1:0]      count0_o,
    output logic [SWT_CNT_W-1:0]      count1_o,
    output logic [SWT_NUM-1:0]        running_o,
    output logic [SWT_NUM-1:0]        fired_o,
    output logic [SWT_NUM-1:0]        irq_o,
    output logic [SWT_NUM-1:0]        wake_o,
    output logic                      cal_busy_o,
    output logic                      cal_done_o,
    output logic [SWT_REF_W-1:0]      cal_result_o
);
    typedef enum logic [3:0] {
        CAL_IDLE = 4'b0001,
        CAL_SYNC = 4'b0010,
        CAL_RUN  = 4'b0100,
        CAL_DONE = 4'b1000
    } swt_cal_state_t;

    // pin synchronisers, free running so no false edge follows reset
    logic                 slow_s1;
    logic                 slow_s2;
    logic                 slow_s3;
    logic                 ref_s1;
    logic                 ref_s2;
    logic                 ref_s3;
    logic                 sleep_s1;
    logic                 sleep_s2;
    wire                  slow_tick;
    wire                  ref_tick;

    // timer state
    logic [SWT_CNT_W-1:0] cnt [SWT_NUM];
    wire  [SWT_NUM-1:0]   fire;

    // calibration state
    swt_cal_state_t       cal_state;
    swt_cal_state_t       next_cal_state;
    logic [SWT_REF_W-1:0] ref_cnt;
    wire                  cal_hold;
    wire                  cal_run;
    wire                  cal_end;
    wire                  ref_step;
    wire  [SWT_REF_W-1:0] ref_inc;
    wire  [SWT_REF_W-1:0] ref_sum;
    wire  [SWT_REF_W-1:0] next_ref_cnt;
    wire  [SWT_REF_W-1:0] next_cal_result;
    wire                  next_cal_busy;
    wire                  next_cal_done;

    always_ff @(posedge clk_i) begin
        slow_s1  <= slow_clk_i;
        slow_s2  <= slow_s1;
        slow_s3  <= slow_s2;
        ref_s1   <= ref_clk_i;
        ref_s2   <= ref_s1;
        ref_s3   <= ref_s2;
        sleep_s1 <= asleep_i;
        sleep_s2 <= sleep_s1;
    end

    assign slow_tick = slow_s2 & ~slow_s3;
    assign ref_tick  = ref_s2 & ~ref_s3;

    // window opens on a slow edge so it spans whole periods only
    assign cal_hold        = (cal_state == CAL_SYNC);
    assign cal_run         = (cal_state == CAL_RUN);
    assign cal_end         = cal_run & fire[0];
    assign ref_step        = cal_run & ref_tick;
    assign ref_inc         = ref_step ? SWT_REF_ONE : SWT_REF_ZERO;
    assign ref_sum         = ref_cnt + ref_inc;
    assign next_ref_cnt    = cal_start_i ? SWT_REF_ZERO : ref_sum;
    assign next_cal_result = cal_end ? ref_sum : cal_result_o;
    assign next_cal_busy   = (next_cal_state == CAL_SYNC) | (next_cal_state == CAL_RUN);
    assign next_cal_done   = (next_cal_state == CAL_DONE);

    always_comb begin
        next_cal_state = cal_state;
        case (cal_state)
            CAL_IDLE: begin
                if (cal_start_i) begin
                    next_cal_state = CAL_SYNC;
                end
            end
            CAL_SYNC: begin
                if (cal_start_i) begin
                    next_cal_state = CAL_SYNC;
                end else if (slow_tick) begin
                    next_cal_state = CAL_RUN;
                end
            end
            CAL_RUN: begin
                if (cal_start_i) begin
                    next_cal_state = CAL_SYNC;
                end else if (cal_end) begin
                    next_cal_state = CAL_DONE;
                end
            end
            CAL_DONE: begin
                if (cal_start_i) begin
                    next_cal_state = CAL_SYNC;
                end
            end
            default: begin
                next_cal_state = CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cal_state    <= CAL_IDLE;
            ref_cnt      <= SWT_REF_ZERO;
            cal_busy_o   <= 1'b0;
            cal_done_o   <= 1'b0;
            cal_result_o <= SWT_REF_ZERO;
        end else begin
            cal_state    <= next_cal_state;
            ref_cnt      <= next_ref_cnt;
            cal_busy_o   <= next_cal_busy;
            cal_done_o   <= next_cal_done;
            cal_result_o <= next_cal_result;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < SWT_NUM; gi++) begin : g_tmr
            wire [SWT_CNT_W-1:0] load_val;
            wire                 do_start;
            wire                 do_stop;
            wire                 hold;
            wire                 step;
            wire                 at_one;
            wire                 at_zero;
            wire [SWT_CNT_W-1:0] dec_val;
            wire [SWT_CNT_W-1:0] run_val;
            wire [SWT_CNT_W-1:0] next_cnt;
            wire                 next_run;
            wire                 next_fired;
            wire                 int_fire;
            wire                 next_irq;
            wire                 next_wake;

            if (gi == 0) begin : g_sel0
                assign load_val = cal_start_i ? SWT_CAL_LOAD : start_val0_i;
                assign do_start = start_i[0] | cal_start_i;
                assign do_stop  = stop_i[0] | cal_end;
                assign hold     = cal_hold;
            end else begin : g_sel1
                assign load_val = start_val1_i;
                assign do_start = start_i[gi];
                assign do_stop  = stop_i[gi];
                assign hold     = 1'b0;
            end

            assign step       = slow_tick & running_o[gi] & ~hold;
            assign at_one     = (cnt[gi] == SWT_CNT_ONE);
            assign at_zero    = (cnt[gi] == SWT_CNT_ZERO);
            assign fire[gi]   = step & at_one;
            assign dec_val    = at_zero ? SWT_ROLL_VAL : cnt[gi] - SWT_CNT_ONE;
            assign run_val    = step ? dec_val : cnt[gi];
            assign next_cnt   = do_start ? load_val : run_val;
            assign next_run   = do_start | (running_o[gi] & ~do_stop);
            // set wins over clear
            assign next_fired = fire[gi] | (fired_o[gi] & ~fired_clear_i);
            assign int_fire   = fire[gi] & int_en_i[gi];
            assign next_irq   = int_fire & ~sleep_s2;
            assign next_wake  = int_fire & sleep_s2;

            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    cnt[gi]       <= SWT_CNT_ZERO;
                    running_o[gi] <= 1'b0;
                    fired_o[gi]   <= 1'b0;
                    irq_o[gi]     <= 1'b0;
                    wake_o[gi]    <= 1'b0;
                end else begin
                    cnt[gi]       <= next_cnt;
                    running_o[gi] <= next_run;
                    fired_o[gi]   <= next_fired;
                    irq_o[gi]     <= next_irq;
                    wake_o[gi]    <= next_wake;
                end
            end
        end
    endgenerate

    // live counts straight from the counters
    assign count0_o = cnt[0];
    assign count1_o = cnt[1];
endmodule : swt_wake_timers

/* File: swt_sva.sv */
// assertion checker for the wake timers
`timescale 1ns/1ps
module swt_sva
    import swt_pkg::*;
(
    input wire logic                 clk_i,
    input wire logic                 rst_n_i,
    input wire logic [SWT_NUM-1:0]   start_i,
    input wire logic [SWT_NUM-1:0]   stop_i,
    input wire logic [SWT_CNT_W-1:0] start_val1_i,
    input wire logic [SWT_NUM-1:0]   int_en_i,
    input wire logic                 fired_clear_i,
    input wire logic                 cal_start_i,
    input wire logic [SWT_CNT_W-1:0] count0_o,
    input wire logic [SWT_CNT_W-1:0] count1_o,
    input wire logic [SWT_NUM-1:0]   running_o,
    input wire logic [SWT_NUM-1:0]   fired_o,
    input wire logic [SWT_NUM-1:0]   irq_o,
    input wire logic [SWT_NUM-1:0]   wake_o,
    input wire logic                 cal_busy_o,
    input wire logic                 cal_done_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_cal_go;
        cal_start_i ##1 cal_busy_o;
    endsequence
    AST_START: assert property (start_i[1] |=>
        running_o[1] && count1_o == $past(start_val1_i)) else $error("start not loaded");
    AST_HOLD: assert property (!running_o[1] && !start_i[1] |=>
        $stable(count1_o)) else $error("stopped count moved");
    AST_STEP: assert property (running_o[1] && !start_i[1] |=>
        count1_o == $past(count1_o) || count1_o == $past(count1_o) - SWT_CNT_ONE
        || count1_o == SWT_ROLL_VAL) else $error("bad count step");
    AST_IRQ: assert property (irq_o[1] |-> fired_o[1] &&
        count1_o == SWT_CNT_ZERO && $past(int_en_i[1])) else $error("bad irq");
    AST_PULSE: assert property (irq_o[1] |=> !irq_o[1]) else $error("irq too long");
    AST_WAKE: assert property (wake_o[0] |-> !irq_o[0] &&
        fired_o[0] && $past(int_en_i[0])) else $error("bad wake");
    AST_CAL_BUSY: assert property (cal_start_i |=> cal_busy_o) else $error("no busy");
    AST_CAL_GO: assert property (s_cal_go |-> !cal_done_o &&
        running_o[0] && count0_o == SWT_CAL_LOAD) else $error("cal load wrong");
    AST_CAL_END: assert property ($fell(cal_busy_o) |-> cal_done_o &&
        !running_o[0] && count0_o == SWT_CNT_ZERO) else $error("cal end wrong");
    AST_RUN_FLAG: assert property (stop_i[1] && !start_i[1] |=>
        !running_o[1]) else $error("stop ignored");
    AST_FIRED_HOLD: assert property (fired_o[1] && !fired_clear_i |=>
        fired_o[1]) else $error("fired flag lost");
endmodule : swt_sva

/* File: test_swt_wake_timers.sv */
// self-checking bench for the wake timers
`timescale 1ns/1ps
module test_swt_wake_timers;
    import swt_pkg::*;
    localparam int        SLOW_HALF = 160;
    localparam int        REF_HALF  = 16;
    localparam int        CAL_EXP   = int'(SWT_CAL_LOAD) * SLOW_HALF / REF_HALF;
    logic                 clk_i = 0, rst_n_i = 0, slow_clk_i = 0, ref_clk_i = 0, asleep_i = 0;
    logic                 fired_clear_i = 0, cal_start_i = 0, cal_busy_o, cal_done_o;
    logic [SWT_NUM-1:0]   start_i = 0, stop_i = 0, int_en_i = 0;
    logic [SWT_NUM-1:0]   running_o, fired_o, irq_o, wake_o;
    logic [SWT_CNT_W-1:0] start_val0_i = 0, start_val1_i = 3, count0_o, count1_o;
    logic [SWT_REF_W-1:0] cal_result_o;
    int                   n_fail = 0, tests_run = 0;
    swt_wake_timers dut (
        .clk_i         (clk_i),
        .rst_n_i       (rst_n_i),
        .slow_clk_i    (slow_clk_i),
        .ref_clk_i     (ref_clk_i),
        .asleep_i      (asleep_i),
        .start_i       (start_i),
        .stop_i        (stop_i),
        .start_val0_i  (start_val0_i),
        .start_val1_i  (start_val1_i),
        .int_en_i      (int_en_i),
        .fired_clear_i (fired_clear_i),
        .cal_start_i   (cal_start_i),
        .count0_o      (count0_o),
        .count1_o      (count1_o),
        .running_o     (running_o),
        .fired_o       (fired_o),
        .irq_o         (irq_o),
        .wake_o        (wake_o),
        .cal_busy_o    (cal_busy_o),
        .cal_done_o    (cal_done_o),
        .cal_result_o  (cal_result_o)
    );
    initial forever #4 clk_i = ~clk_i;
    initial forever #SLOW_HALF slow_clk_i = ~slow_clk_i;
    initial forever #REF_HALF ref_clk_i = ~ref_clk_i;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        $display("checks %0d fails %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic tick;
        @(negedge clk_i);
        {start_i, stop_i, fired_clear_i, cal_start_i} = '0;
    endtask : tick
    task automatic wait_on(input bit sel);
        int i;
        for (i = 0; i < 4000; i++) begin
            tick();
            if (sel ? cal_done_o === 1'b1 : fired_o[1] === 1'b1) return;
        end
        n_fail++;
        summarize();
    endtask : wait_on
    initial begin
        repeat (10) tick();
        check({running_o, fired_o, count1_o}, 0);
        rst_n_i = 1;
        int_en_i = 2'b10;
        start_i = 2'b10;
        tick();
        check({running_o, count1_o}, {2'b10, 41'h3});
        wait_on(0);
        check({irq_o, count1_o}, {2'b10, SWT_CNT_ZERO});
        fired_clear_i = 1;
        tick();
        check(fired_o, 0);
        repeat (39) tick();
        check(count1_o, SWT_ROLL_VAL);
        stop_i = 2'b11;
        fired_clear_i = 1;
        tick();
        repeat (45) tick();
        check({running_o, count1_o}, {2'b00, SWT_ROLL_VAL});
        asleep_i = 1;
        int_en_i = 2'b01;
        cal_start_i = 1;
        tick();
        check({cal_busy_o, count0_o}, {1'b1, SWT_CAL_LOAD});
        wait_on(1);
        check({irq_o, wake_o}, 4'b0001);
        check({cal_busy_o, cal_done_o}, 2'b01);
        check(cal_result_o >= CAL_EXP - 1 && cal_result_o <= CAL_EXP + 1, 1);
        check({running_o[0], fired_o[0], count0_o}, {2'b01, SWT_CNT_ZERO});
        start_val1_i = 1;
        start_i = 2'b10;
        tick();
        wait_on(0);
        check({irq_o, wake_o}, 4'b0000);
        check(fired_o, 2'b11);
        summarize();
    end
endmodule : test_swt_wake_timers
bind swt_wake_timers swt_sva chk (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .start_i       (start_i),
    .stop_i        (stop_i),
    .start_val1_i  (start_val1_i),
    .int_en_i      (int_en_i),
    .fired_clear_i (fired_clear_i),
    .cal_start_i   (cal_start_i),
    .count0_o      (count0_o),
    .count1_o      (count1_o),
    .running_o     (running_o),
    .fired_o       (fired_o),
    .irq_o         (irq_o),
    .wake_o        (wake_o),
    .cal_busy_o    (cal_busy_o),
    .cal_done_o    (cal_done_o)
);
